// ---- verilog/rlo_pkg.sv ----
// Package for the lane output configuration register slice.
// Assumes an 8-bit register port with 8-bit addresses from the management bus front end.
package rlo_pkg;
  localparam logic [7:0] RLO_ADDR_SWING    = 8'h3b;
  localparam logic [7:0] RLO_ADDR_DEEMPH   = 8'h3c;
  localparam logic [7:0] RLO_ADDR_SDTH     = 8'h3d;
  localparam logic [7:0] RLO_ADDR_SPARE_A  = 8'h3e;
  localparam logic [7:0] RLO_ADDR_SPARE_B  = 8'h3f;
  localparam logic [7:0] RLO_RST_SWING     = 8'had;
  localparam logic [7:0] RLO_RST_DEEMPH    = 8'h02;
  localparam logic [7:0] RLO_RST_SDTH      = 8'h00;
  localparam logic [7:0] RLO_RST_SPARE     = 8'h00;
  localparam int         RLO_SCP_BIT       = 7;
  localparam int         RLO_TERM_BIT      = 7;
  localparam int         RLO_FIELD_MSB     = 2;
  localparam int         RLO_ASSERT_MSB    = 3;
  localparam int         RLO_ASSERT_LSB    = 2;
  localparam int         RLO_DEASSERT_MSB  = 1;
  localparam logic [3:0] RLO_SWING_KEEP    = 4'h5;
  localparam logic [2:0] RLO_SWING_UNITY   = 3'h6;
  localparam logic [2:0] RLO_DEEMPH_NONE   = 3'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rlo_req_t;

  typedef struct packed {
    logic       short_protect_en;
    logic [2:0] swing_ratio;
    logic [2:0] deemph_level;
    logic [1:0] assert_thresh;
    logic [1:0] deassert_thresh;
    logic [2:0] swing_range_cut;
  } rlo_cfg_t;
endpackage

// ---- verilog/rlo_thresh_sel.sv ----
// Selects the signal-detect thresholds from register or pin setting.
// Assumes the global override bit arrives as a level from the global register.
`timescale 1ns/1ps
module rlo_thresh_sel (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       override_i,
  input  wire logic [1:0] reg_assert_i,
  input  wire logic [1:0] reg_deassert_i,
  input  wire logic [1:0] pin_assert_i,
  input  wire logic [1:0] pin_deassert_i,
  output logic      [1:0] assert_o,
  output logic      [1:0] deassert_o
);
  logic [1:0] nxt_assert;
  logic [1:0] nxt_deassert;
  assign nxt_assert   = override_i ? reg_assert_i : pin_assert_i;
  assign nxt_deassert = override_i ? reg_deassert_i : pin_deassert_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      assert_o   <= 2'h0;
      deassert_o <= 2'h0;
    end else begin
      assert_o   <= nxt_assert;
      deassert_o <= nxt_deassert;
    end
  end

  chk_override_path: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    override_i |=> (assert_o == $past(reg_assert_i)))
    else $error("assert threshold not taken from register under override");
  chk_pin_path: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !override_i |=> (deassert_o == $past(pin_deassert_i)))
    else $error("deassert threshold not taken from pin without override");
endmodule // rlo_thresh_sel

// ---- verilog/rlo_lane_regs.sv ----
// Register slice for side A lane two: swing, de-emphasis, signal-detect thresholds.
// Assumes a byte register port with single-cycle write and read strobes.
`timescale 1ns/1ps
module rlo_lane_regs
  import rlo_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic            rst_i,
  input  rlo_pkg::rlo_req_t    req_i,
  output logic      [7:0]      rdata_o,
  output logic                 rvalid_o,
  input  wire logic            term_status_i,
  input  wire logic            sd_override_i,
  input  wire logic [1:0]      pin_assert_i,
  input  wire logic [1:0]      pin_deassert_i,
  output rlo_pkg::rlo_cfg_t    cfg_o
);
  import rlo_pkg::*;

  logic [7:0] swing_ff;
  logic [7:0] deemph_ff;
  logic [3:0] sdth_ff;
  logic [7:0] rdata_ff;
  logic       rvalid_ff;
  logic [7:0] nxt_rdata;
  logic [1:0] sel_assert;
  logic [1:0] sel_deassert;

  wire hit_swing  = req_i.addr == RLO_ADDR_SWING;
  wire hit_deemph = req_i.addr == RLO_ADDR_DEEMPH;
  wire hit_sdth   = req_i.addr == RLO_ADDR_SDTH;
  // Per-register strobes, so the checks below name the access they watch.
  wire wr_swing   = req_i.wr && hit_swing;
  wire wr_deemph  = req_i.wr && hit_deemph;
  wire wr_sdth    = req_i.wr && hit_sdth;
  wire rd_swing   = req_i.rd && hit_swing;
  wire rd_deemph  = req_i.rd && hit_deemph;
  wire rd_sdth    = req_i.rd && hit_sdth;

  // The termination status is read live, so a read shows its level at the taking edge.
  wire [7:0] deemph_view = {term_status_i, 4'h0, deemph_ff[RLO_FIELD_MSB:0]};

  assign nxt_rdata = hit_swing  ? swing_ff :
                     hit_deemph ? deemph_view :
                     hit_sdth   ? {4'h0, sdth_ff} : RLO_RST_SPARE;

  // Reserved de-emphasis and threshold bits are dropped on write, so they read back as zero.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      swing_ff  <= RLO_RST_SWING;
      deemph_ff <= RLO_RST_DEEMPH;
      sdth_ff   <= RLO_RST_SDTH[3:0];
    end else if (req_i.wr) begin
      if (hit_swing) begin
        swing_ff <= req_i.wdata;
      end
      if (hit_deemph) begin
        deemph_ff <= {5'h0, req_i.wdata[RLO_FIELD_MSB:0]};
      end
      if (hit_sdth) begin
        sdth_ff <= req_i.wdata[3:0];
      end
    end
  end

  // The read answer stands until the next read; its valid lasts one cycle.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= req_i.rd;
      if (req_i.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // One register stage, so a pin change and an override change land on the same edge.
  rlo_thresh_sel u_thresh (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .override_i     (sd_override_i),
    .reg_assert_i   (sdth_ff[RLO_ASSERT_MSB:RLO_ASSERT_LSB]),
    .reg_deassert_i (sdth_ff[RLO_DEASSERT_MSB:0]),
    .pin_assert_i   (pin_assert_i),
    .pin_deassert_i (pin_deassert_i),
    .assert_o       (sel_assert),
    .deassert_o     (sel_deassert)
  );

  assign rdata_o  = rdata_ff;
  assign rvalid_o = rvalid_ff;
  assign cfg_o.short_protect_en = swing_ff[RLO_SCP_BIT];
  assign cfg_o.swing_ratio      = swing_ff[RLO_FIELD_MSB:0];
  assign cfg_o.deemph_level     = deemph_ff[RLO_FIELD_MSB:0];
  assign cfg_o.assert_thresh    = sel_assert;
  assign cfg_o.deassert_thresh  = sel_deassert;
  // The analog driver reduces its range by the selected attenuation step.
  assign cfg_o.swing_range_cut  = deemph_ff[RLO_FIELD_MSB:0];

  chk_swing_reset: assert property (@(posedge sys_clk_i)
    rst_i |=> (swing_ff == RLO_RST_SWING))
    else $error("swing register reset value wrong");
  chk_scp_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && hit_swing) |=> (cfg_o.short_protect_en == $past(req_i.wdata[7])))
    else $error("protection enable did not follow write");
  chk_term_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i.rd && hit_deemph) |=> (rdata_o[RLO_TERM_BIT] == $past(term_status_i)))
    else $error("termination status not reported");
  chk_deemph_reset: assert property (@(posedge sys_clk_i)
    rst_i |=> (cfg_o.deemph_level == RLO_RST_DEEMPH[2:0]))
    else $error("de-emphasis reset value wrong");
  chk_range_cut: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_deemph |=> (cfg_o.swing_range_cut == $past(req_i.wdata[RLO_FIELD_MSB:0])))
    else $error("range cut does not track attenuation");
  chk_sdth_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && hit_sdth) |=> (sdth_ff == $past(req_i.wdata[3:0])))
    else $error("threshold register did not update");
  chk_deassert_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (sd_override_i && !(req_i.wr && hit_sdth)) |=> ##1
      (!$past(sd_override_i) || cfg_o.deassert_thresh == $past(sdth_ff[1:0], 2)))
    else $error("de-assert threshold selection wrong");
  chk_read_latency: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i.rd |=> rvalid_o)
    else $error("read answer missing one cycle after read");
  chk_spare_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i.rd && !hit_swing && !hit_deemph && !hit_sdth) |=> (rdata_o == 8'h00))
    else $error("spare register not zero");

  // Reset values are checked one edge after reset is sampled, so the first tick is never read.
  chk_sdth_reset: assert property (@(posedge sys_clk_i)
    rst_i |=> (sdth_ff == RLO_RST_SDTH[3:0]))
    else $error("threshold register reset value wrong");
  chk_scp_reset: assert property (@(posedge sys_clk_i)
    rst_i |=> (cfg_o.short_protect_en == RLO_RST_SWING[RLO_SCP_BIT]))
    else $error("protection enable reset value wrong");
  chk_thresh_reset: assert property (@(posedge sys_clk_i)
    rst_i |=> (cfg_o.assert_thresh == RLO_RST_SDTH[3:2] &&
               cfg_o.deassert_thresh == RLO_RST_SDTH[1:0]))
    else $error("selected thresholds reset value wrong");

  // Each register takes a write on the next edge and holds it until the next write.
  chk_swing_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_swing |=> (swing_ff == $past(req_i.wdata)))
    else $error("swing register did not take the write");
  chk_ratio_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_swing |=> (cfg_o.swing_ratio == $past(req_i.wdata[RLO_FIELD_MSB:0])))
    else $error("swing ratio did not follow write");
  chk_deemph_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_deemph |=> (cfg_o.deemph_level == $past(req_i.wdata[RLO_FIELD_MSB:0])))
    else $error("de-emphasis level did not follow write");
  chk_swing_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !wr_swing |=> $stable(swing_ff))
    else $error("swing register changed without a write");
  chk_scp_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !wr_swing |=> $stable(cfg_o.short_protect_en))
    else $error("protection enable changed without a write");
  chk_deemph_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !wr_deemph |=> $stable(cfg_o.deemph_level))
    else $error("de-emphasis level changed without a write");
  chk_cut_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !wr_deemph |=> $stable(cfg_o.swing_range_cut))
    else $error("range cut changed without a write");
  chk_sdth_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !wr_sdth |=> $stable(sdth_ff))
    else $error("threshold register changed without a write");

  // A read answers with the value held at the taking edge; a write in that cycle is not seen.
  chk_swing_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_swing |=> (rdata_o == $past(swing_ff)))
    else $error("swing register read back wrong");
  chk_deemph_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_deemph |=> (rdata_o[6:0] == {4'h0, $past(deemph_ff[RLO_FIELD_MSB:0])}))
    else $error("de-emphasis register read back wrong");
  chk_sdth_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_sdth |=> (rdata_o == {4'h0, $past(sdth_ff)}))
    else $error("threshold register read back wrong");
  chk_read_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !req_i.rd |=> !rvalid_o)
    else $error("read valid without a read");
  chk_rdata_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !req_i.rd |=> $stable(rdata_o))
    else $error("read data changed without a read");

  // The selected thresholds follow their source, register or pin, one edge later.
  chk_reg_assert: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sd_override_i |=> (cfg_o.assert_thresh == $past(sdth_ff[RLO_ASSERT_MSB:RLO_ASSERT_LSB])))
    else $error("assert threshold not taken from register");
  chk_reg_deassert: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sd_override_i |=> (cfg_o.deassert_thresh == $past(sdth_ff[RLO_DEASSERT_MSB:0])))
    else $error("de-assert threshold not taken from register");
  chk_pin_assert: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !sd_override_i |=> (cfg_o.assert_thresh == $past(pin_assert_i)))
    else $error("assert threshold not taken from pin");
  chk_pin_deassert: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !sd_override_i |=> (cfg_o.deassert_thresh == $past(pin_deassert_i)))
    else $error("de-assert threshold not taken from pin");
  chk_assert_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (sd_override_i && !wr_sdth) |=> ##1
      (!$past(sd_override_i) || cfg_o.assert_thresh == $past(sdth_ff[3:2], 2)))
    else $error("assert threshold selection wrong");

  // Coverage of the main configuration scenarios.
  cov_swing_unity: cover property (@(posedge sys_clk_i)
    cfg_o.swing_ratio == RLO_SWING_UNITY);
  cov_deemph_none: cover property (@(posedge sys_clk_i)
    cfg_o.deemph_level == RLO_DEEMPH_NONE);
  cov_override_on: cover property (@(posedge sys_clk_i) sd_override_i ##1 !sd_override_i);
  cov_term_seen: cover property (@(posedge sys_clk_i) req_i.rd && hit_deemph && term_status_i);
  cov_scp_off: cover property (@(posedge sys_clk_i) !cfg_o.short_protect_en);
endmodule // rlo_lane_regs

// ---- testbench/rlo_host_model.sv ----
// Host model for the lane register slice: drives single-cycle register requests.
// Assumes the bench clock; requests change only at the falling edge.
`timescale 1ns/1ps
module rlo_host_model (
  input  wire logic         sys_clk_i,
  output rlo_pkg::rlo_req_t req_o
);
  import rlo_pkg::*;

  initial req_o = '0;

  // One request per call, held over exactly one taking edge.
  // The released bus shows inverted address and data rather than the last values.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (w && a == RLO_ADDR_SWING) v[6:3] = RLO_SWING_KEEP;
    @(negedge sys_clk_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: v};
    @(negedge sys_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask
endmodule // rlo_host_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the lane register slice.
// Assumes the host model as the only source of register requests.
`timescale 1ns/1ps
module tb_top;
  import rlo_pkg::*;
  logic       sys_clk_i = 0, rst_i = 1, term_status_i = 0, sd_override_i = 0;
  logic [1:0] pin_assert_i = 0, pin_deassert_i = 0;
  rlo_req_t   req;
  logic [7:0] rdata_o;
  logic       rvalid_o;
  rlo_cfg_t   cfg_o;
  int         mismatches = 0, checks = 0;
  logic [7:0] exp_q[$];

  always #2 sys_clk_i = ~sys_clk_i;

  rlo_host_model i_rlo_host_model (.sys_clk_i(sys_clk_i), .req_o(req));
  rlo_lane_regs i_rlo_lane_regs (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .term_status_i(term_status_i),
    .sd_override_i(sd_override_i), .pin_assert_i(pin_assert_i),
    .pin_deassert_i(pin_deassert_i), .cfg_o(cfg_o));

  task automatic check_cfg(input string what, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic check_rd(input logic [7:0] e, input logic [7:0] s);
    check_cfg("rdata", e, s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_rlo_host_model.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_rlo_host_model.access(1'b0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Each read answer is compared with the oldest noted expectation.
  always @(negedge sys_clk_i) if (rvalid_o === 1'b1)
    check_rd(exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rdata_o);

  initial begin
    logic [7:0] v;
    logic [2:0] c;
    void'($urandom(32'h1ed8));
    repeat (20) @(negedge sys_clk_i);
    rst_i = 0;
    term_status_i = 1;
    check_cfg("scp", 8'h01, {7'h0, cfg_o.short_protect_en});
    rd(RLO_ADDR_SWING, 8'had);
    rd(RLO_ADDR_DEEMPH, 8'h82);
    rd(RLO_ADDR_SDTH, 8'h00);
    rd(RLO_ADDR_SPARE_B, 8'h00);
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      v = {1'($urandom % 2), 4'h5, c};
      wr(RLO_ADDR_SWING, v);
      wr(RLO_ADDR_DEEMPH, {5'h0, c});
      term_status_i = c[1];
      settle();
      check_cfg("scp", {7'h0, v[7]}, {7'h0, cfg_o.short_protect_en});
      check_cfg("swing", {5'h0, c}, {5'h0, cfg_o.swing_ratio});
      check_cfg("deemph", {5'h0, c}, {5'h0, cfg_o.deemph_level});
      check_cfg("cut", {5'h0, c}, {5'h0, cfg_o.swing_range_cut});
      rd(RLO_ADDR_SWING, v);
      rd(RLO_ADDR_DEEMPH, {c[1], 4'h0, c});
    end
    $display("test swing and de-emphasis codes done");
    term_status_i = 1'b0;
    wr(RLO_ADDR_DEEMPH, 8'hff);
    wr(RLO_ADDR_SDTH, 8'hf9);
    wr(RLO_ADDR_SPARE_A, 8'haa);
    wr(8'h40, 8'h55);
    rd(RLO_ADDR_DEEMPH, 8'h07);
    rd(RLO_ADDR_SDTH, 8'h09);
    rd(RLO_ADDR_SPARE_A, 8'h00);
    rd(8'h40, 8'h00);
    $display("test reserved writes done");
    for (int k = 0; k < 16; k++) begin
      v = {4'h0, 4'(k)};
      sd_override_i = !v[1];
      pin_assert_i = 2'($urandom);
      pin_deassert_i = 2'($urandom);
      wr(RLO_ADDR_SDTH, v);
      settle();
      check_cfg("assert", {6'h0, sd_override_i ? v[3:2] : pin_assert_i},
                {6'h0, cfg_o.assert_thresh});
      check_cfg("deassert", {6'h0, sd_override_i ? v[1:0] : pin_deassert_i},
                {6'h0, cfg_o.deassert_thresh});
    end
    $display("test threshold override done");
    for (int n = 0; n < 10 && exp_q.size() > 0; n++) @(negedge sys_clk_i);
    if (exp_q.size() > 0) mismatches++;
    print_verdict();
  end
endmodule // tb_top
